// ==== rtl/clock_select_pkg.sv ====
// What this block does
// - Manual mode, pin selection off: choice 00 picks input one, 01 input two.
// - Manual mode, pin selection on: select pin picks input, register choice ignored.
// - Force holdover bit set enters digital hold, overriding every selection control.
// - Squelch bit set disables output clocks while calibration runs; clear keeps them.
// - Method field: 00 manual, 01 automatic non-revertive, 10 revertive, 11 reserved.
// - Five-bit history delay field sets delay for digital hold frequency history.
// - Two-bit drive field applies only to outputs in CMOS format.
// - Output two format: 001 off, 010 CMOS, 011/101/110/111 other kinds.
// - Output one format uses the same encoding as output two.
// - Output never squelched setting overrides squelch during calibration.
package clock_select_pkg;

    // Register offsets
    localparam logic [7:0] select_hold_offset   = 8'h03;
    localparam logic [7:0] method_delay_offset  = 8'h04;
    localparam logic [7:0] drive_offset         = 8'h05;
    localparam logic [7:0] format_offset        = 8'h06;

    // Reset values
    localparam logic [7:0] select_hold_reset    = 8'h05;
    localparam logic [7:0] method_delay_reset   = 8'h12;
    localparam logic [7:0] drive_reset          = 8'hed;
    localparam logic [7:0] format_reset         = 8'h2d;
    localparam logic [7:0] unmapped_read_value  = 8'h00;

    // Writable bit masks
    localparam logic [7:0] select_hold_mask     = 8'hf0;
    localparam logic [7:0] method_delay_mask    = 8'hdf;
    localparam logic [7:0] drive_mask           = 8'hc0;
    localparam logic [7:0] format_mask          = 8'h3f;

    // Field positions
    localparam int choice_msb      = 7;
    localparam int choice_lsb      = 6;
    localparam int holdover_bit    = 5;
    localparam int squelch_bit     = 4;
    localparam int method_msb      = 7;
    localparam int method_lsb      = 6;
    localparam int delay_msb       = 4;
    localparam int delay_lsb       = 0;
    localparam int drive_msb       = 7;
    localparam int drive_lsb       = 6;
    localparam int out_two_msb     = 5;
    localparam int out_two_lsb     = 3;
    localparam int out_one_msb     = 2;
    localparam int out_one_lsb     = 0;

    // Manual clock choice codes
    localparam logic [1:0] choice_input_one = 2'h0;
    localparam logic [1:0] choice_input_two = 2'h1;

    typedef enum logic [1:0] {
        method_manual        = 2'h0,
        method_non_revertive = 2'h1,
        method_revertive     = 2'h2,
        method_reserved      = 2'h3
    } method_type;

    // Output format codes
    localparam logic [2:0] format_disabled  = 3'h1;
    localparam logic [2:0] format_cmos      = 3'h2;
    localparam logic [2:0] format_low_lvds  = 3'h3;
    localparam logic [2:0] format_lvpecl    = 3'h5;
    localparam logic [2:0] format_cml       = 3'h6;
    localparam logic [2:0] format_lvds      = 3'h7;

    // One-hot kind positions
    localparam int kind_disabled  = 0;
    localparam int kind_cmos      = 1;
    localparam int kind_low_lvds  = 2;
    localparam int kind_lvpecl    = 3;
    localparam int kind_cml       = 4;
    localparam int kind_lvds      = 5;
    localparam int kind_width     = 6;

endpackage

// ==== rtl/output_format_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface output_format_if;
    import clock_select_pkg::*;
    logic [2:0]            code;
    logic [kind_width-1:0] kind;
    logic                  legal;

    modport source
    (
        output code,
        input  kind,
        input  legal
    );

    modport decoder
    (
        input  code,
        output kind,
        output legal
    );
endinterface

`default_nettype wire

// ==== rtl/output_format_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none

module output_format_decoder
    import clock_select_pkg::*;
(
    // Format code in, kind out
    output_format_if.decoder fmt
);

    always_comb
    begin
        fmt.kind  = '0;
        fmt.legal = 1'b1;
        case (fmt.code)
            format_disabled: fmt.kind[kind_disabled] = 1'b1;
            format_cmos:     fmt.kind[kind_cmos]     = 1'b1;
            format_low_lvds: fmt.kind[kind_low_lvds] = 1'b1;
            format_lvpecl:   fmt.kind[kind_lvpecl]   = 1'b1;
            format_cml:      fmt.kind[kind_cml]      = 1'b1;
            format_lvds:     fmt.kind[kind_lvds]     = 1'b1;
            // Reserved codes drive nothing
            default:         fmt.legal = 1'b0;
        endcase
    end

endmodule

`default_nettype wire

// ==== rtl/clock_select_regs.sv ====
`timescale 1ns/1ps
`default_nettype none

module clock_select_regs
    import clock_select_pkg::*;
(
    // Clock and reset
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rst,

    // Register port from the serial bus engine
    input  wire logic [7:0]            i_reg_addr,
    input  wire logic [7:0]            i_reg_wdata,
    input  wire logic                  i_reg_wr,
    output logic      [7:0]            o_reg_rdata,

    // Selection inputs
    input  wire logic                  i_clock_select_pin,
    input  wire logic                  i_pin_selection_enable,
    input  wire logic                  i_auto_choice,

    // Calibration, squelch and bypass inputs
    input  wire logic                  i_internal_calibration,
    input  wire logic                  i_output_never_squelched,
    input  wire logic                  i_bypass_request,

    // Selection results
    output logic                       o_active_input_two,
    output logic                       o_force_holdover,
    output logic                       o_auto_select,
    output logic                       o_revertive,
    output logic      [4:0]            o_history_delay,

    // Output buffer control
    output logic      [1:0]            o_output_enable,
    output logic      [1:0]            o_cmos_drive_enable,
    output logic      [1:0]            o_cmos_drive_strength,
    output logic      [kind_width-1:0] o_output_one_kind,
    output logic      [kind_width-1:0] o_output_two_kind,
    output logic                       o_bypass_cmos_conflict
);

    typedef struct packed {
        logic [7:0]            select_hold;
        logic [7:0]            method_delay;
        logic [7:0]            drive;
        logic [7:0]            format;
        logic [7:0]            rdata;
        logic                  active_two;
        logic [1:0]            out_enable;
        logic [1:0]            cmos_enable;
        logic [kind_width-1:0] kind_one;
        logic [kind_width-1:0] kind_two;
        logic                  conflict;
    } state_type;

    state_type             state;
    state_type             next_state;
    method_type            method;
    logic [1:0]            choice;
    logic                  squelched;
    logic [kind_width-1:0] kind [2];
    logic [1:0]            legal;

    output_format_if fmt_bus [2] ();

    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_fmt
            assign kind[i]  = fmt_bus[i].kind;
            assign legal[i] = fmt_bus[i].legal;
            output_format_decoder u_decoder
            (
                .fmt (fmt_bus[i])
            );
        end
    endgenerate

    assign fmt_bus[0].code = state.format[out_one_msb:out_one_lsb];
    assign fmt_bus[1].code = state.format[out_two_msb:out_two_lsb];

    assign method = method_type'(state.method_delay[method_msb:method_lsb]);
    assign choice = state.select_hold[choice_msb:choice_lsb];

    // Never-squelched wins over squelch during calibration
    assign squelched = state.select_hold[squelch_bit] & i_internal_calibration
                       & ~i_output_never_squelched;

    always_comb
    begin
        next_state = state;

        // Only writable bits take write data
        if (i_reg_wr)
        begin
            if (i_reg_addr == select_hold_offset)
            begin
                next_state.select_hold = (i_reg_wdata & select_hold_mask)
                                         | (select_hold_reset & ~select_hold_mask);
            end
            else if (i_reg_addr == method_delay_offset)
            begin
                next_state.method_delay = (i_reg_wdata & method_delay_mask)
                                          | (method_delay_reset & ~method_delay_mask);
            end
            else if (i_reg_addr == drive_offset)
            begin
                next_state.drive = (i_reg_wdata & drive_mask)
                                   | (drive_reset & ~drive_mask);
            end
            else if (i_reg_addr == format_offset)
            begin
                next_state.format = (i_reg_wdata & format_mask)
                                    | (format_reset & ~format_mask);
            end
        end

        // Read data lags the address by one cycle
        if (i_reg_addr == select_hold_offset)
        begin
            next_state.rdata = state.select_hold;
        end
        else if (i_reg_addr == method_delay_offset)
        begin
            next_state.rdata = state.method_delay;
        end
        else if (i_reg_addr == drive_offset)
        begin
            next_state.rdata = state.drive;
        end
        else if (i_reg_addr == format_offset)
        begin
            next_state.rdata = state.format;
        end
        else
        begin
            next_state.rdata = unmapped_read_value;
        end

        // Holdover freezes the choice; reserved codes also keep the last choice
        if (!state.select_hold[holdover_bit])
        begin
            case (method)
                method_manual:
                begin
                    if (i_pin_selection_enable)
                    begin
                        next_state.active_two = i_clock_select_pin;
                    end
                    else if (choice == choice_input_one)
                    begin
                        next_state.active_two = 1'b0;
                    end
                    else if (choice == choice_input_two)
                    begin
                        next_state.active_two = 1'b1;
                    end
                end
                method_non_revertive,
                method_revertive:
                begin
                    next_state.active_two = i_auto_choice;
                end
                default:
                begin
                    next_state.active_two = state.active_two;
                end
            endcase
        end

        // Reserved formats are held off so a bad code never drives a pin
        for (int i = 0; i < 2; i++)
        begin
            next_state.out_enable[i]  = legal[i] & ~kind[i][kind_disabled] & ~squelched;
            next_state.cmos_enable[i] = kind[i][kind_cmos];
        end
        next_state.kind_one = kind[0];
        next_state.kind_two = kind[1];

        // Flags a host setting that bypass cannot serve
        next_state.conflict = i_bypass_request
                              & (kind[0][kind_cmos] | kind[1][kind_cmos]);
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            state              <= '0;
            state.select_hold  <= select_hold_reset;
            state.method_delay <= method_delay_reset;
            state.drive        <= drive_reset;
            state.format       <= format_reset;
        end
        else
        begin
            state <= next_state;
        end
    end

    assign o_reg_rdata            = state.rdata;
    assign o_active_input_two     = state.active_two;
    assign o_force_holdover       = state.select_hold[holdover_bit];
    assign o_auto_select          = (method == method_non_revertive)
                                    | (method == method_revertive);
    assign o_revertive            = (method == method_revertive);
    assign o_history_delay        = state.method_delay[delay_msb:delay_lsb];
    assign o_output_enable        = state.out_enable;
    assign o_cmos_drive_enable    = state.cmos_enable;
    assign o_cmos_drive_strength  = state.drive[drive_msb:drive_lsb];
    assign o_output_one_kind      = state.kind_one;
    assign o_output_two_kind      = state.kind_two;
    assign o_bypass_cmos_conflict = state.conflict;

endmodule

`default_nettype wire

// ==== testbench/reg_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module reg_host_model
(
    // Clock
    input  wire logic       i_clk_sys,
    // Register port
    output logic      [7:0] o_reg_addr,
    output logic      [7:0] o_reg_wdata,
    output logic            o_reg_wr,
    output logic            o_bypass_request
);
    initial
    begin
        o_reg_addr = 8'h00;
        o_reg_wdata = 8'h00;
        o_reg_wr = 1'b0;
        o_bypass_request = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        o_reg_addr = a;
        o_reg_wdata = d;
        o_reg_wr = 1'b1;
        // Drop bypass before a CMOS format lands, raise it only once the new format holds
        if (a == 8'h06 && (d[5:3] == 3'h2 || d[2:0] == 3'h2))
            o_bypass_request = 1'b0;
        @(negedge i_clk_sys);
        o_reg_wr = 1'b0;
        o_reg_wdata = ~d;
        if (a == 8'h06 && d[5:3] != 3'h2 && d[2:0] != 3'h2)
            o_bypass_request = 1'b1;
    endtask

    task automatic rd(input logic [7:0] a);
        @(negedge i_clk_sys);
        o_reg_addr = a;
    endtask
endmodule

`default_nettype wire

// ==== testbench/clock_select_regs_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none

module clock_select_regs_monitor
    import clock_select_pkg::*;
(
    // Watched ports
    input wire logic                  i_clk_sys,
    input wire logic                  i_rst,
    input wire logic [7:0]            i_reg_addr,
    input wire logic [7:0]            i_reg_wdata,
    input wire logic                  i_reg_wr,
    input wire logic [7:0]            o_reg_rdata,
    input wire logic                  i_clock_select_pin,
    input wire logic                  i_pin_selection_enable,
    input wire logic                  i_internal_calibration,
    input wire logic                  i_output_never_squelched,
    input wire logic                  i_bypass_request,
    input wire logic                  o_bypass_cmos_conflict,
    input wire logic                  o_active_input_two,
    input wire logic                  o_force_holdover,
    input wire logic                  o_auto_select,
    input wire logic                  o_revertive,
    input wire logic [4:0]            o_history_delay,
    input wire logic [1:0]            o_output_enable,
    input wire logic [1:0]            o_cmos_drive_enable,
    input wire logic [kind_width-1:0] o_output_one_kind,
    input wire logic [kind_width-1:0] o_output_two_kind
);
    // Shadow of fields not visible at the ports
    logic [1:0] m;
    logic [1:0] c;
    logic       s;

    default clocking @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            m <= 2'h0;
            c <= 2'h0;
            s <= 1'b0;
        end
        else if (i_reg_wr && i_reg_addr == 8'h03)
        begin
            c <= i_reg_wdata[7:6];
            s <= i_reg_wdata[4];
        end
        else if (i_reg_wr && i_reg_addr == 8'h04)
            m <= i_reg_wdata[7:6];
    end

    a_unmapped_reads: assert property (
        (i_reg_addr < 8'h03 || i_reg_addr > 8'h06) |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_reserved_fixed: assert property (
        i_reg_addr == 8'h03 |=> o_reg_rdata[3:0] == 4'h5)
        else $error("reserved bits changed");
    a_history_delay: assert property (
        i_reg_wr && i_reg_addr == 8'h04 |=> o_history_delay == $past(i_reg_wdata[4:0]))
        else $error("history delay wrong");
    a_method_decode: assert property (
        i_reg_wr && i_reg_addr == 8'h04 |=> o_auto_select == (m == 2'h1 || m == 2'h2)
        && o_revertive == (m == 2'h2))
        else $error("method decode wrong");
    a_holdover_freeze: assert property (
        o_force_holdover |=> $stable(o_active_input_two))
        else $error("active input moved in holdover");
    a_manual_choice: assert property (
        m == 2'h0 && !o_force_holdover && !i_pin_selection_enable && !c[1]
        |=> o_active_input_two == $past(c[0]))
        else $error("register choice not followed");
    a_pin_choice: assert property (
        m == 2'h0 && !o_force_holdover && i_pin_selection_enable
        |=> o_active_input_two == $past(i_clock_select_pin))
        else $error("select pin not followed");
    a_squelch_cal: assert property (
        i_internal_calibration && s && !i_output_never_squelched |=> o_output_enable == 2'h0)
        else $error("outputs not squelched");
    a_enable_kept: assert property (
        !i_internal_calibration || !s || i_output_never_squelched
        |=> o_output_enable == {|o_output_two_kind[5:1], |o_output_one_kind[5:1]})
        else $error("output enable wrong");
    a_cmos_drive: assert property (
        o_cmos_drive_enable == {o_output_two_kind[1], o_output_one_kind[1]})
        else $error("drive enable not tied to cmos");
    a_format_two: assert property (
        i_reg_wr && i_reg_addr == 8'h06 |=> ##1 o_output_two_kind[1:0]
        == {$past(i_reg_wdata[5:3], 2) == 3'h2, $past(i_reg_wdata[5:3], 2) == 3'h1})
        else $error("output two format wrong");
    a_bypass_conflict: assert property (
        o_bypass_cmos_conflict == ($past(i_bypass_request)
        && (o_output_one_kind[1] || o_output_two_kind[1])))
        else $error("bypass conflict flag wrong");
endmodule

bind clock_select_regs clock_select_regs_monitor i_clock_select_regs_monitor (.*);

`default_nettype wire

// ==== testbench/clock_select_output_format_regs_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module clock_select_output_format_regs_tb;
    import clock_select_pkg::*;
    logic                  i_clk_sys = 1'b0;
    logic                  i_rst = 1'b1;
    logic [7:0]            addr;
    logic [7:0]            wdata;
    logic                  wr;
    logic                  bypass;
    logic [7:0]            rdata;
    logic                  pin, pen, auto, cal, nsq, act, hold, asel, rev, rd_pend, rd_d;
    logic                  conflict;
    logic [4:0]            hist;
    logic [1:0]            en, cen, drv;
    logic [kind_width-1:0] k1, k2;
    logic [7:0]            notes[$];
    logic [7:0]            d;
    logic [5:0]            e1, e2;
    int                    errors, num_checks, seed;
    logic [7:0] av[5] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h07};
    logic [7:0] rv[5] = '{select_hold_reset, method_delay_reset, drive_reset, format_reset, 8'h0};
    logic [7:0] mk[5] = '{select_hold_mask, method_delay_mask, drive_mask, format_mask, 8'h0};

    always #20 i_clk_sys = ~i_clk_sys;

    reg_host_model i_reg_host_model (.i_clk_sys(i_clk_sys), .o_reg_addr(addr),
        .o_reg_wdata(wdata), .o_reg_wr(wr), .o_bypass_request(bypass));

    clock_select_regs i_clock_select_regs (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .o_reg_rdata(rdata),
        .i_clock_select_pin(pin), .i_pin_selection_enable(pen), .i_auto_choice(auto),
        .i_internal_calibration(cal), .i_output_never_squelched(nsq),
        .i_bypass_request(bypass), .o_active_input_two(act), .o_force_holdover(hold),
        .o_auto_select(asel), .o_revertive(rev), .o_history_delay(hist),
        .o_output_enable(en), .o_cmos_drive_enable(cen), .o_cmos_drive_strength(drv),
        .o_output_one_kind(k1), .o_output_two_kind(k2), .o_bypass_cmos_conflict(conflict));

    function automatic logic [5:0] kind_of(input logic [2:0] f);
        case (f)
            3'h1: kind_of = 6'h01;
            3'h2: kind_of = 6'h02;
            3'h3: kind_of = 6'h04;
            3'h5: kind_of = 6'h08;
            3'h6: kind_of = 6'h10;
            3'h7: kind_of = 6'h20;
            default: kind_of = 6'h00;
        endcase
    endfunction

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_reg_host_model.rd(a);
        notes.push_back(e);
        rd_pend = 1'b1;
        @(negedge i_clk_sys);
        rd_pend = 1'b0;
    endtask

    task automatic close_out;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge i_clk_sys)
        rd_d <= rd_pend;

    always @(negedge i_clk_sys)
        if (rd_d && notes.size() > 0)
            chk("rdata", notes.pop_front(), rdata);

    initial
    begin
        #200000;
        errors++;
        close_out;
    end

    initial
    begin
        {pin, pen, auto, cal, nsq, rd_pend} = 6'h0;
        seed = 32'h8efb0ce8;
        repeat (3) @(negedge i_clk_sys);
        i_rst = 1'b0;
        for (int k = 0; k < 5; k++)
            rd(av[k], rv[k]);
        chk("enable", 8'h03, {6'h0, en});
        for (int r = 0; r < 20; r++)
        begin
            d = 8'($random(seed));
            i_reg_host_model.wr(av[r % 5], d);
            rd(av[r % 5], (d & mk[r % 5]) | (rv[r % 5] & ~mk[r % 5]));
        end
        for (int f = 0; f < 8; f++)
        begin
            i_reg_host_model.wr(8'h05, {2'(f % 3), 6'h0});
            i_reg_host_model.wr(8'h06, {2'h0, 3'(f), 3'(7 - f)});
            e1 = kind_of(3'(7 - f));
            e2 = kind_of(3'(f));
            @(negedge i_clk_sys);
            chk("kind one", {2'h0, e1}, {2'h0, k1});
            chk("kind two", {2'h0, e2}, {2'h0, k2});
            chk("cmos enable", {6'h0, e2[1], e1[1]}, {6'h0, cen});
            chk("drive", 8'(f % 3), {6'h0, drv});
            chk("conflict", 8'h00, {7'h0, conflict});
        end
        i_reg_host_model.wr(8'h04, 8'h00);
        for (int j = 0; j < 8; j++)
        begin
            {pen, pin, auto} = 3'($random(seed));
            i_reg_host_model.wr(8'h03, {1'b0, j[0], 6'h0});
            @(negedge i_clk_sys);
            chk("active", {7'h0, pen ? pin : j[0]}, {7'h0, act});
        end
        for (int m = 0; m < 4; m++)
        begin
            d = {2'(m), 1'b0, 5'($random(seed))};
            auto = m[0];
            i_reg_host_model.wr(8'h04, d);
            @(negedge i_clk_sys);
            chk("history", {3'h0, d[4:0]}, {3'h0, hist});
            chk("auto", {6'h0, m == 2, m == 1 || m == 2}, {6'h0, rev, asel});
            if (m == 1 || m == 2)
                chk("auto active", {7'h0, auto}, {7'h0, act});
        end
        // Reserved method must hold the last choice even when the auto choice moves
        auto = 1'b0;
        @(negedge i_clk_sys);
        chk("reserved method", 8'h01, {7'h0, act});
        i_reg_host_model.wr(8'h04, 8'h00);
        pen = 1'b0;
        i_reg_host_model.wr(8'h03, 8'h00);
        i_reg_host_model.wr(8'h03, 8'h60);
        repeat (3) @(negedge i_clk_sys);
        chk("holdover", 8'h01, {7'h0, hold});
        chk("held input", 8'h00, {7'h0, act});
        i_reg_host_model.wr(8'h06, 8'h2d);
        i_reg_host_model.wr(8'h03, 8'h10);
        cal = 1'b1;
        repeat (2) @(negedge i_clk_sys);
        chk("squelched", 8'h00, {6'h0, en});
        nsq = 1'b1;
        repeat (2) @(negedge i_clk_sys);
        chk("never squelched", 8'h03, {6'h0, en});
        repeat (2) @(negedge i_clk_sys);
        close_out;
    end
endmodule

`default_nettype wire
